/* design/fsc_defs.svh */
// Register map, field positions, reload values and timing counts of the frequency control bank.
`ifndef FSC_DEFS_SVH
`define FSC_DEFS_SVH
`define FSC_ADDR_HSDIV 8'h07
`define FSC_ADDR_DIVLO 8'h08
`define FSC_ADDR_MUL3 8'h09
`define FSC_ADDR_MUL2 8'h0a
`define FSC_ADDR_MUL1 8'h0b
`define FSC_ADDR_MUL0 8'h0c
`define FSC_ADDR_CTRL 8'h87
`define FSC_ADDR_FRZ 8'h89
`define FSC_CTRL_APPLY 6
`define FSC_CTRL_HOLD_MUL 5
`define FSC_CTRL_HOLD_CV 4
`define FSC_CTRL_RELOAD 0
`define FSC_FRZ_VARIANT 7
`define FSC_FRZ_HOLD_OSC 4
`define FSC_APPLY_VALUE 8'h40
`define FSC_FREEZE_FIXED 8'h10
`define FSC_FREEZE_VC 8'h90
`define FSC_NV_HSDIV 8'h01
`define FSC_NV_DIVLO 8'hc2
`define FSC_NV_MUL 32'h00000000
`define FSC_APPLY_CYCLES 4'h8
`define FSC_RELOAD_CYCLES 4'h4
`define FSC_APB_READY_IDLE 2'h0
`endif

/* design/fsc_pkg.sv */
// Types of the frequency control bank; only the controller end uses them.
package fsc_pkg;
	typedef enum logic [3:0] {
		FSC_IDLE = 4'b0001,
		FSC_SETUP = 4'b0010,
		FSC_ACCESS = 4'b0100,
		FSC_DONE = 4'b1000
	} fsc_link_state_t;
	typedef logic [37:0] fsc_mul_t;
endpackage : fsc_pkg

/* design/fsc_link_if.sv */
// Register access link between the controller and the oscillator register bank.
`timescale 1ns/100ps
`default_nettype none
interface fsc_link_if;
	logic req;
	logic wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic ack;
	modport ctrl (output req, output wr, output addr, output wdata, input rdata, input ack);
	modport dev (input req, input wr, input addr, input wdata, output rdata, output ack);
endinterface : fsc_link_if
`default_nettype wire

/* design/fsc_device.sv */
// Oscillator register bank with divider, multiplier, apply, freeze and reload logic.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`include "fsc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module fsc_device #(
	parameter bit VC_VARIANT = 1'b0,
	parameter logic [3:0] FRZ_LOW_BITS = 4'h0
) (
	// Clock, enable and reset.
	input wire logic core_clk_i,
	input wire logic ce_i,
	input wire logic rst_i,
	// Register link.
	fsc_link_if.dev link,
	// Working settings toward the synthesiser.
	output logic [2:0] high_speed_divider_code_o,
	output logic [3:0] high_speed_ratio_o,
	output logic [6:0] output_divider_code_o,
	output logic [7:0] output_ratio_o,
	output logic [37:0] reference_multiplier_word_o,
	output logic [9:0] multiplier_integer_o,
	output logic [27:0] multiplier_fraction_o,
	output logic hold_oscillator_o,
	output logic hold_control_voltage_word_o,
	output logic apply_pulse_o
);
	// ----------------------------------------------------------------------
	// Register storage
	// ----------------------------------------------------------------------
	logic [7:0] hsdiv_reg;
	logic [7:0] divlo_reg;
	logic [31:0] mul_reg;
	logic apply_new_frequency;
	logic hold_mul;
	logic hold_cv;
	logic apply_done;
	logic reload;
	logic hold_osc;
	logic [3:0] apply_cnt;
	logic [3:0] reload_cnt;
	logic wr_hit;
	logic reload_done;

	// A write is taken in the first cycle of the request only, so it lands once.
	assign wr_hit = ce_i && link.req && link.wr && !link.ack;
	assign reload_done = reload && (reload_cnt == `FSC_RELOAD_CYCLES);
	assign apply_done = apply_new_frequency && apply_cnt == `FSC_APPLY_CYCLES && !hold_osc;

	// Data registers, overwritten by a finished reload.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hsdiv_reg <= 8'h00;
			divlo_reg <= 8'h00;
			mul_reg <= 32'h00000000;
		end else if (ce_i) begin
			if (reload_done) begin
				hsdiv_reg <= `FSC_NV_HSDIV;
				divlo_reg <= `FSC_NV_DIVLO;
				mul_reg <= `FSC_NV_MUL;
			end else if (wr_hit) begin
				unique case (link.addr)
					`FSC_ADDR_HSDIV: hsdiv_reg <= link.wdata;
					`FSC_ADDR_DIVLO: divlo_reg <= link.wdata;
					`FSC_ADDR_MUL3: mul_reg[31:24] <= link.wdata;
					`FSC_ADDR_MUL2: mul_reg[23:16] <= link.wdata;
					`FSC_ADDR_MUL1: mul_reg[15:8] <= link.wdata;
					`FSC_ADDR_MUL0: mul_reg[7:0] <= link.wdata;
					default: ;
				endcase
			end
		end
	end

	// Control register; self-clearing bits let a new write win over the clear.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			apply_new_frequency <= 1'b0;
			hold_mul <= 1'b0;
			hold_cv <= 1'b0;
			reload <= 1'b0;
		end else if (ce_i) begin
			if (wr_hit && link.addr == `FSC_ADDR_CTRL) begin
				// A written zero leaves a pending bit to its own clear; a written one wins.
				apply_new_frequency <= link.wdata[`FSC_CTRL_APPLY] |
					(apply_new_frequency && !apply_done);
				hold_mul <= link.wdata[`FSC_CTRL_HOLD_MUL];
				hold_cv <= VC_VARIANT & link.wdata[`FSC_CTRL_HOLD_CV];
				reload <= link.wdata[`FSC_CTRL_RELOAD] | (reload && !reload_done);
			end else begin
				if (apply_done) begin
					apply_new_frequency <= 1'b0;
				end
				if (reload_done) begin
					reload <= 1'b0;
				end
			end
		end
	end

	// Freeze register; only the hold bit is writable.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_osc <= 1'b0;
		end else if (ce_i && wr_hit && link.addr == `FSC_ADDR_FRZ) begin
			hold_osc <= link.wdata[`FSC_FRZ_HOLD_OSC];
		end
	end

	// Apply and reload progress counters.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			apply_cnt <= 4'h0;
			reload_cnt <= 4'h0;
		end else if (ce_i) begin
			apply_cnt <= (apply_new_frequency && apply_cnt != `FSC_APPLY_CYCLES) ?
				apply_cnt + 4'h1 : (apply_new_frequency ? apply_cnt : 4'h0);
			reload_cnt <= (reload && !reload_done) ? reload_cnt + 4'h1 : 4'h0;
		end
	end

	// Dividers load on apply unless the oscillator is held; the multiplier word also waits while the multiplier is held.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			high_speed_divider_code_o <= 3'h0;
			output_divider_code_o <= 7'h00;
			reference_multiplier_word_o <= 38'h0;
			apply_pulse_o <= 1'b0;
		end else if (ce_i) begin
			apply_pulse_o <= 1'b0;
			if (apply_new_frequency && apply_cnt == `FSC_APPLY_CYCLES - 4'h1) begin
				if (!hold_osc) begin
					high_speed_divider_code_o <= hsdiv_reg[7:5];
					output_divider_code_o <= {hsdiv_reg[4:0], divlo_reg[7:6]};
					apply_pulse_o <= 1'b1;
				end
				if (!hold_osc && !hold_mul) begin
					reference_multiplier_word_o <= {divlo_reg[5:0], mul_reg};
				end
			end
		end
	end

	// Derived ratios and fixed point view.
	always_comb begin
		unique case (high_speed_divider_code_o)
			3'h0: high_speed_ratio_o = 4'h4;
			3'h1: high_speed_ratio_o = 4'h5;
			3'h2: high_speed_ratio_o = 4'h6;
			3'h3: high_speed_ratio_o = 4'h7;
			3'h5: high_speed_ratio_o = 4'h9;
			3'h7: high_speed_ratio_o = 4'hb;
			default: high_speed_ratio_o = 4'h0;
		endcase
		output_ratio_o = {1'b0, output_divider_code_o} + 8'h01;
		if (output_ratio_o[0] && output_divider_code_o != 7'h00) begin
			output_ratio_o = output_ratio_o + 8'h01;
		end
	end
	assign multiplier_integer_o = reference_multiplier_word_o[37:28];
	assign multiplier_fraction_o = reference_multiplier_word_o[27:0];
	assign hold_oscillator_o = hold_osc;
	assign hold_control_voltage_word_o = hold_cv;

	// Read path and single-cycle acknowledge.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			link.rdata <= 8'h00;
			link.ack <= 1'b0;
		end else if (ce_i) begin
			link.ack <= link.req && !link.ack;
			unique case (link.addr)
				`FSC_ADDR_HSDIV: link.rdata <= hsdiv_reg;
				`FSC_ADDR_DIVLO: link.rdata <= divlo_reg;
				`FSC_ADDR_MUL3: link.rdata <= mul_reg[31:24];
				`FSC_ADDR_MUL2: link.rdata <= mul_reg[23:16];
				`FSC_ADDR_MUL1: link.rdata <= mul_reg[15:8];
				`FSC_ADDR_MUL0: link.rdata <= mul_reg[7:0];
				`FSC_ADDR_CTRL: link.rdata <= {1'b0, apply_new_frequency, hold_mul, hold_cv,
					3'h0, reload};
				`FSC_ADDR_FRZ: link.rdata <= {VC_VARIANT, 2'b00, hold_osc, FRZ_LOW_BITS};
				default: link.rdata <= 8'h00;
			endcase
		end
	end
endmodule : fsc_device
`default_nettype wire

/* design/fsc_ctrl.sv */
// Controller that turns APB register reads and writes into link accesses of the oscillator bank.
`include "fsc_defs.svh"
`timescale 1ns/100ps
`default_nettype none
module fsc_ctrl (
	// Clock, enable and reset.
	input wire logic core_clk_i,
	input wire logic ce_i,
	input wire logic rst_i,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Register link.
	fsc_link_if.ctrl link
);
	// ----------------------------------------------------------------------
	// APB window: byte address 4*n maps to link register n.
	// Software keeps reserved bits by read-modify-write.
	// Frequency change order is freeze, write, release, apply.
	// ----------------------------------------------------------------------
	fsc_pkg::fsc_link_state_t state;
	logic [7:0] rd_hold;

	// One link access per APB access; pready once the link acknowledges.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= fsc_pkg::FSC_IDLE;
			link.req <= 1'b0;
			link.wr <= 1'b0;
			link.addr <= 8'h00;
			link.wdata <= 8'h00;
			rd_hold <= 8'h00;
		end else if (ce_i) begin
			unique case (state)
				fsc_pkg::FSC_IDLE: if (psel && !penable) begin
					state <= fsc_pkg::FSC_SETUP;
				end
				fsc_pkg::FSC_SETUP: begin
					link.req <= 1'b1;
					link.wr <= pwrite;
					link.addr <= paddr[9:2];
					link.wdata <= pwdata[7:0];
					state <= fsc_pkg::FSC_ACCESS;
				end
				fsc_pkg::FSC_ACCESS: if (link.ack) begin
					link.req <= 1'b0;
					rd_hold <= link.rdata;
					state <= fsc_pkg::FSC_DONE;
				end
				fsc_pkg::FSC_DONE: state <= fsc_pkg::FSC_IDLE;
			endcase
		end
	end

	assign pready = (state == fsc_pkg::FSC_DONE);
	assign pslverr = 1'b0;
	assign prdata = {24'h000000, rd_hold};
endmodule : fsc_ctrl
`default_nettype wire

/* testbench/fsc_link_monitor.sv */
// Link protocol and register read checks of the frequency control bank.
`timescale 1ns/100ps
`default_nettype none
module fsc_link_monitor #(
	parameter bit VC_VARIANT = 1'b0,
	parameter logic [3:0] FRZ_LOW_BITS = 4'h0
) (
	// Clock and reset.
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Link signals.
	input wire logic req,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic ack
);
	logic [3:0] age;
	logic held;
	wire logic rd = ack && !wr;
	wire logic cw = ack && wr && addr == 8'h87;
	// Counts cycles since the last control write and follows the oscillator hold.
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			age <= 4'h0;
			held <= 1'b0;
		end else begin
			age <= cw ? 4'h0 : age + {3'h0, age != 4'hf};
			if (ack && wr && addr == 8'h89) held <= wdata[4];
		end
	end
	// -------------------------------------------------------------
	// Properties
	// -------------------------------------------------------------
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	property p_ack_next; $rose(req) |=> ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_one; ack |=> !ack; endproperty
	a_ack_one: assert property (p_ack_one) else $error("ack long");
	property p_req_drop; ack |=> !req; endproperty
	a_req_drop: assert property (p_req_drop) else $error("req kept");
	property p_req_hold; req && !ack |=> req && $stable({wr, addr, wdata}); endproperty
	a_req_hold: assert property (p_req_hold) else $error("req moved");
	property p_ctrl_rsvd; rd && addr == 8'h87 |-> rdata[7] == 1'b0 && rdata[3:1] == 3'h0; endproperty
	a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("ctrl reserved set");
	property p_frz; rd && addr == 8'h89 |-> rdata == {VC_VARIANT, 2'h0, held, FRZ_LOW_BITS}; endproperty
	a_frz: assert property (p_frz) else $error("freeze read bad");
	property p_apply; rd && addr == 8'h87 && age > 4'hb && !held |-> !rdata[6]; endproperty
	a_apply: assert property (p_apply) else $error("apply kept");
	property p_reload; rd && addr == 8'h87 && age > 4'h7 |-> !rdata[0]; endproperty
	a_reload: assert property (p_reload) else $error("reload kept");
	property p_unmapped; rd && addr == 8'h20 |-> rdata == 8'h00; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read");
	c_apply: cover property (cw && wdata == 8'h40);
	c_held: cover property (rd && addr == 8'h89 && held);
	c_reload: cover property (cw && wdata[0]);
endmodule : fsc_link_monitor
`default_nettype wire

/* testbench/tb_top.sv */
// Self-checking bench of controller and register bank joined by the link.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic [6:0] n1;
	logic [37:0] mul;
	logic [3:0] hsr;
	logic [7:0] n1r;
	logic [9:0] mi;
	logic [27:0] mf;
	logic hosc;
	logic hcv;
	logic [7:0] q;
	logic ce = 1'b1;
	logic [2:0] hsd;
	logic ap;
	logic slverr;
	logic err;
	int pulses = 0;
	int mismatches = 0;
	int tests_run = 0;
	int cyc = 0;
	fsc_link_if link ();
	fsc_ctrl fsc_ctrl_i (.core_clk_i, .ce_i(ce), .rst_i, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr(slverr), .link(link));
	fsc_device fsc_device_i (.core_clk_i, .ce_i(ce), .rst_i, .link(link),
		.high_speed_divider_code_o(hsd), .high_speed_ratio_o(hsr), .output_divider_code_o(n1),
		.output_ratio_o(n1r), .reference_multiplier_word_o(mul), .multiplier_integer_o(mi),
		.multiplier_fraction_o(mf), .hold_oscillator_o(hosc), .hold_control_voltage_word_o(hcv),
		.apply_pulse_o(ap));
	fsc_link_monitor fsc_link_monitor_i (.core_clk_i, .rst_i, .req(link.req), .wr(link.wr),
		.addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
	// Makes the 25 MHz clock.
	initial begin
		forever #20 core_clk_i = ~core_clk_i;
	end
	// -------------------------------------------------------------
	// Tasks
	// -------------------------------------------------------------
	task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
		tests_run++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// One APB transfer to register r; read data lands in q.
	task automatic apb(input logic w, input logic [7:0] r, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, r, 2'h0};
		pwdata <= {24'h0, d};
		@(posedge core_clk_i);
		penable <= 1'b1;
		do @(posedge core_clk_i); while (pready !== 1'b1);
		q = prdata[7:0];
		err = slverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk_i);
	endtask : apb
	task automatic rdc(input string n, input logic [7:0] r, input logic [7:0] e);
		apb(1'b0, r, 8'h00);
		chk(n, q, e);
		chk("slverr", err, 1'b0);
	endtask : rdc
	task automatic t_reset();
		apb(1'b0, 8'h87, 8'h00);
		chk("ctrl_rst", q & 8'hc3, 8'h00);
		rdc("frz_rst", 8'h89, 8'h00);
		$display("reset test done.");
	endtask : t_reset
	task automatic t_cfg(input logic [2:0] c, input logic [6:0] k, input logic [37:0] w,
			input logic [3:0] er);
		int p;
		apb(1'b1, 8'h89, 8'h10);
		chk("hold_osc", hosc, 1'b1);
		apb(1'b1, 8'h07, {c, k[6:2]});
		apb(1'b1, 8'h08, {k[1:0], w[37:32]});
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h09 + 8'(i), w[31 - 8 * i -: 8]);
		end
		rdc("div_mul_top", 8'h08, {k[1:0], w[37:32]});
		apb(1'b1, 8'h89, 8'h00);
		p = pulses;
		apb(1'b1, 8'h87, 8'h40);
		repeat (12) @(posedge core_clk_i);
		rdc("apply_clr", 8'h87, 8'h00);
		chk("mul", mul, w);
		chk("int_frac", {mi, mf}, w);
		chk("n1", n1, k);
		chk("n1_ratio", n1r, (k == 0 || k[0]) ? k + 1 : k + 2);
		chk("hs_ratio", hsr, er);
		chk("hs_code", hsd, c);
		chk("apply_pulse", pulses, p + 1);
		$display("config test done.");
	endtask : t_cfg
	task automatic t_hold();
		apb(1'b0, 8'h89, 8'h00);
		apb(1'b1, 8'h89, q | 8'h10);
		rdc("frz_only4", 8'h89, 8'h10);
		apb(1'b1, 8'h89, 8'h00);
		apb(1'b1, 8'h87, 8'h20);
		chk("hold_cv", hcv, 1'b0);
		rdc("hold_mul_rd", 8'h87, 8'h20);
		apb(1'b1, 8'h0c, 8'h00);
		apb(1'b1, 8'h87, 8'h60);
		repeat (12) @(posedge core_clk_i);
		chk("mul_held", mul, 38'h15_89ab_cdef);
		apb(1'b1, 8'h87, 8'h40);
		repeat (12) @(posedge core_clk_i);
		chk("mul_new", mul, 38'h15_89ab_cd00);
		rdc("unmapped", 8'h20, 8'h00);
		apb(1'b1, 8'h20, q);
		rdc("unmapped_wr", 8'h20, 8'h00);
		$display("hold test done.");
	endtask : t_hold
	task automatic t_reload();
		apb(1'b1, 8'h87, 8'h01);
		repeat (8) @(posedge core_clk_i);
		rdc("reload_clr", 8'h87, 8'h00);
		rdc("reload_val", 8'h08, 8'hc2);
		$display("reload test done.");
	endtask : t_reload
	// A low clock enable freezes a pending apply until it rises again.
	task automatic t_ce();
		apb(1'b1, 8'h87, 8'h40);
		ce <= 1'b0;
		repeat (20) @(posedge core_clk_i);
		chk("ce_frozen", mul, 38'h15_89ab_cd00);
		ce <= 1'b1;
		repeat (12) @(posedge core_clk_i);
		chk("ce_mul", mul, 38'h02_0000_0000);
		chk("ce_n1", n1, 7'h07);
		rdc("ce_apply_clr", 8'h87, 8'h00);
		$display("clock enable test done.");
	endtask : t_ce
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d.", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : give_verdict
	// Cuts a hung run short.
	always @(posedge core_clk_i) begin
		cyc <= cyc + 1;
		if (ap === 1'b1) pulses <= pulses + 1;
		if (cyc == 20000) begin
			mismatches++;
			give_verdict();
		end
	end
	// Main sequence.
	initial begin
		repeat (20) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		t_reset();
		t_cfg(3'b101, 7'h09, 38'h2a_1234_5678, 4'h9);
		t_cfg(3'b111, 7'h02, 38'h15_89ab_cdef, 4'hb);
		t_hold();
		t_reload();
		t_ce();
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
